/* logic/parallel_port.sv */
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// [R01] port off means no external access
// [R02] optionally freeze while cpu idles
// [R03] mux field places address on pins
// [R04] three enables gate strobe and byte outputs
// [R05] select field makes select pins address
// [R06] polarity bits for latch, selects, byte
// [R07] polarities ignored on address-line pins
// [R08] strobe polarity meaning depends on mode
// [R09] busy reads one during master transfer
// [R10] completion signalling: event, stall, none
// [R11] event on buffer three access
// [R12] address steps up or down
// [R13] legacy slave buffers auto advance
// [R14] wide mode makes two byte transfers
// [R15] mode field picks master or slave
// [R16] setup wait and address phase 1-4
// [R17] strobe wait adds 0 to 15
// [R18] hold wait of 1-4 cycles
// [R19] zero strobe wait drops setup, hold
// [R20] idle cycle between bus operations
// [R21] full input write sets sticky overflow
// [R22] address register drives address lines
// [R23] software avoids reserved codes
module parallel_port #(
  parameter int STEP_BITS = 11
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic cpu_idle, // processor in idle mode
  output logic port_event, // completion pulse
  input wire port_pkg::pins_in_type pins_in, // external inputs
  output port_pkg::pins_out_type pins // external outputs
);

  if (STEP_BITS < 1 || STEP_BITS > 14) begin : g_check
    $error("STEP_BITS must lie in 1..14");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic level(input logic act, input logic pol);
    level = act ? pol : !pol;
  endfunction

  function automatic port_pkg::phase_type next_phase(
      input port_pkg::phase_type st, input port_pkg::control_type c,
      input port_pkg::mode_type m);
    port_pkg::phase_type after_addr;
    after_addr = (m.strobe_wait == 4'h0) ? port_pkg::ST_STROBE
                                         : port_pkg::ST_SETUP;
    case (st)
      port_pkg::ST_IDLE, port_pkg::ST_GAP: begin
        next_phase = (c.addr_data_mux_sel != port_pkg::MUX_SEPARATE)
                   ? port_pkg::ST_ADDR_LOW : after_addr;
      end
      port_pkg::ST_ADDR_LOW: begin
        next_phase = (c.addr_data_mux_sel == port_pkg::MUX_FULL)
                   ? port_pkg::ST_ADDR_HIGH : after_addr;
      end
      port_pkg::ST_ADDR_HIGH: next_phase = after_addr;
      port_pkg::ST_SETUP: next_phase = port_pkg::ST_STROBE;
      port_pkg::ST_STROBE: begin
        next_phase = (m.strobe_wait == 4'h0) ? port_pkg::ST_GAP
                                             : port_pkg::ST_HOLD;
      end
      port_pkg::ST_HOLD: next_phase = port_pkg::ST_GAP;
      default: next_phase = port_pkg::ST_IDLE;
    endcase
  endfunction

  // cycles in a phase, minus one
  function automatic logic [3:0] phase_len(
      input port_pkg::phase_type st, input port_pkg::mode_type m);
    case (st)
      port_pkg::ST_ADDR_LOW, port_pkg::ST_ADDR_HIGH, port_pkg::ST_SETUP:
        phase_len = (m.strobe_wait == 4'h0) ? 4'h0 // R16 R19
                                            : {2'h0, m.setup_wait};
      port_pkg::ST_STROBE: phase_len = m.strobe_wait; // R17
      port_pkg::ST_HOLD: phase_len = {2'h0, m.hold_wait}; // R18
      default: phase_len = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] step_addr(input logic [15:0] a,
                                            input logic [1:0] sel);
    logic [15:0] r;
    r = a;
    if (sel == port_pkg::STEP_UP)
      r[STEP_BITS-1:0] = a[STEP_BITS-1:0] + 1'b1;
    else if (sel == port_pkg::STEP_DOWN)
      r[STEP_BITS-1:0] = a[STEP_BITS-1:0] - 1'b1;
    step_addr = r;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  port_pkg::control_type ctrl;
  port_pkg::mode_type mode_r;
  port_pkg::phase_type state;
  port_pkg::pins_out_type next_pins;
  logic [15:0] addr_q, wr_data, rd_data, status;
  logic [3:0] cnt, in_full, out_empty;
  logic byte_hi, start_req, is_write, last_strobe, xfer_done;
  logic pend, pend_write, stall_wait, ovf, prev_wr, prev_rd;
  logic [7:0] pend_off;
  logic [7:0] in_buf [4];
  logic [7:0] out_buf [4];
  logic [1:0] rd_ptr, wr_ptr, idx_w, idx_r;
  logic [31:0] read_value;

  wire active = ctrl.port_on && !(ctrl.halt_in_idle && cpu_idle); // R01 R02
  wire master = mode_r.port_mode_sel[1]; // R15
  wire busy = start_req || (state != port_pkg::ST_IDLE);
  wire take = hsel && htrans[1] && hready;
  wire wr_en = pend && pend_write;
  wire data_req = pend && (pend_off == port_pkg::OFF_DATA) && master;
  wire stall_acc = take && haddr[7:0] == port_pkg::OFF_DATA && master
                   && mode_r.interrupt_select == port_pkg::EVT_STALL;
  wire in_xfer = state != port_pkg::ST_IDLE && state != port_pkg::ST_GAP;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign status = {&in_full, ovf, 2'h0, in_full, &out_empty, 3'h0,
                   out_empty};

  always_comb begin
    case (haddr[7:0])
      port_pkg::OFF_CONTROL: read_value = {16'h0000, ctrl};
      port_pkg::OFF_MODE: read_value = {16'h0000, busy, mode_r[14:0]}; // R09
      port_pkg::OFF_ADDRESS: read_value = {16'h0000, addr_q};
      port_pkg::OFF_DATA: read_value = {16'h0000, rd_data};
      port_pkg::OFF_STATUS: read_value = {16'h0000, status};
      port_pkg::OFF_OUT_BYTES:
        read_value = {out_buf[3], out_buf[2], out_buf[1], out_buf[0]};
      port_pkg::OFF_IN_BYTES:
        read_value = {in_buf[3], in_buf[2], in_buf[1], in_buf[0]};
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_off <= 8'h00;
    end else begin
      pend <= take;
      if (take) begin
        pend_write <= hwrite;
        pend_off <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      stall_wait <= 1'b0;
    end else if (stall_acc) begin
      hreadyout <= 1'b0; // R10
      stall_wait <= 1'b1;
      if (!hwrite)
        hrdata <= read_value;
    end else if (stall_wait && (xfer_done || !ctrl.port_on)) begin
      hreadyout <= 1'b1;
      stall_wait <= 1'b0;
      if (!pend_write)
        hrdata <= {16'h0000, rd_data};
    end else if (take && !hwrite) begin
      hrdata <= read_value;
    end
  end

  // ****************************************************************
  // configuration and address registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= port_pkg::CONTROL_RESET;
      mode_r <= port_pkg::MODE_RESET;
      addr_q <= port_pkg::ADDRESS_RESET;
    end else begin
      if (wr_en && pend_off == port_pkg::OFF_CONTROL)
        ctrl <= {hwdata[15], 1'h0, hwdata[13:0]};
      if (wr_en && pend_off == port_pkg::OFF_MODE)
        mode_r <= {1'h0, hwdata[14:0]};
      if (wr_en && pend_off == port_pkg::OFF_ADDRESS)
        addr_q <= hwdata[15:0]; // R22
      else if (xfer_done)
        addr_q <= step_addr(addr_q, mode_r.step_select); // R12
    end
  end

  // ****************************************************************
  // master sequencer
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= port_pkg::ST_IDLE;
      cnt <= 4'h0;
      byte_hi <= 1'b0;
      start_req <= 1'b0;
      is_write <= 1'b0;
      wr_data <= 16'h0000;
      xfer_done <= 1'b0;
      last_strobe <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      last_strobe <= active && state == port_pkg::ST_STROBE && cnt == 4'h0;
      if (!ctrl.port_on) begin
        state <= port_pkg::ST_IDLE; // R01
        byte_hi <= 1'b0;
        start_req <= 1'b0;
      end else begin
        // a data access while busy is dropped
        if (data_req && !busy) begin
          start_req <= 1'b1;
          is_write <= pend_write;
          if (pend_write)
            wr_data <= hwdata[15:0];
        end
        if (active) begin
          if (state == port_pkg::ST_IDLE) begin
            if (start_req) begin
              state <= next_phase(state, ctrl, mode_r);
              cnt <= phase_len(next_phase(state, ctrl, mode_r), mode_r);
              start_req <= 1'b0;
              byte_hi <= 1'b0;
            end
          end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (state == port_pkg::ST_GAP) begin // R20
            if (mode_r.wide_data_sel && !byte_hi) begin // R14
              byte_hi <= 1'b1;
              state <= next_phase(state, ctrl, mode_r);
              cnt <= phase_len(next_phase(state, ctrl, mode_r), mode_r);
            end else begin
              state <= port_pkg::ST_IDLE;
              xfer_done <= 1'b1;
            end
          end else begin
            state <= next_phase(state, ctrl, mode_r); // R19
            cnt <= phase_len(next_phase(state, ctrl, mode_r), mode_r);
          end
        end
      end
    end
  end

  // pins lag the sequencer by one cycle, so sample one cycle late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= 16'h0000;
    end else if (last_strobe && !is_write) begin
      if (byte_hi)
        rd_data[15:8] <= pins_in.data_in; // R14
      else
        rd_data[7:0] <= pins_in.data_in;
    end
  end

  // ****************************************************************
  // slave port
  // ****************************************************************
  wire slave_on = active && !master;
  wire cs_now = pins_in.select_one_in == ctrl.select_one_polarity;
  wire wr_now = cs_now
                && pins_in.write_strobe_in == ctrl.write_strobe_polarity;
  wire rd_now = cs_now
                && pins_in.read_strobe_in == ctrl.read_strobe_polarity;
  wire s_wr = slave_on && wr_now && !prev_wr;
  wire s_rd = slave_on && rd_now && !prev_rd;
  wire buffered = mode_r.port_mode_sel == port_pkg::MODE_LEGACY
                  && mode_r.step_select == port_pkg::STEP_BUFFER;
  wire sw_in_read = pend && !pend_write
                    && pend_off == port_pkg::OFF_IN_BYTES;
  wire sw_out_write = wr_en && pend_off == port_pkg::OFF_OUT_BYTES;
  wire ovf_clear = wr_en && pend_off == port_pkg::OFF_STATUS
                   && !hwdata[port_pkg::OVERFLOW_BIT];
  wire slave_evt = (s_wr || s_rd)
      && (mode_r.interrupt_select == port_pkg::EVT_END
          || (mode_r.interrupt_select == port_pkg::EVT_BUF3 // R11
              && ((s_wr && idx_w == port_pkg::LAST_BUFFER)
                  || (s_rd && idx_r == port_pkg::LAST_BUFFER))));

  always_comb begin
    idx_w = 2'h0;
    idx_r = 2'h0;
    if (mode_r.port_mode_sel == port_pkg::MODE_ADDRESSED) begin
      idx_w = pins_in.location_in;
      idx_r = pins_in.location_in;
    end else if (buffered) begin
      idx_w = wr_ptr; // R13
      idx_r = rd_ptr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_wr <= 1'b0;
      prev_rd <= 1'b0;
      in_full <= 4'h0;
      out_empty <= port_pkg::OUT_EMPTY_RESET;
      ovf <= 1'b0;
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        in_buf[i] <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else begin
      prev_wr <= wr_now;
      prev_rd <= rd_now;
      // hardware set wins over the software clear in the same cycle
      in_full <= (sw_in_read ? 4'h0 : in_full)
                 | ((s_wr && !in_full[idx_w]) ? 4'h1 << idx_w : 4'h0);
      out_empty <= (sw_out_write ? 4'h0 : out_empty)
                   | (s_rd ? 4'h1 << idx_r : 4'h0);
      ovf <= (ovf && !ovf_clear) || (s_wr && in_full[idx_w]); // R21
      if (s_wr && !in_full[idx_w]) begin
        in_buf[idx_w] <= pins_in.data_in;
        if (buffered)
          wr_ptr <= wr_ptr + 2'h1; // R13
      end
      if (s_rd && buffered)
        rd_ptr <= rd_ptr + 2'h1;
      if (sw_out_write)
        for (int i = 0; i < 4; i++)
          out_buf[i] <= hwdata[8*i +: 8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      port_event <= 1'b0;
    else
      port_event <= (xfer_done
                     && mode_r.interrupt_select == port_pkg::EVT_END)
                    || slave_evt; // R10
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  always_comb begin
    next_pins = '0;
    if (ctrl.port_on && master) begin // R01
      case (state)
        port_pkg::ST_ADDR_LOW: next_pins.data_out = addr_q[7:0]; // R03
        port_pkg::ST_ADDR_HIGH: next_pins.data_out = addr_q[15:8];
        default: next_pins.data_out = byte_hi ? wr_data[15:8]
                                              : wr_data[7:0];
      endcase
      next_pins.data_oe = state == port_pkg::ST_ADDR_LOW
          || state == port_pkg::ST_ADDR_HIGH
          || (is_write && in_xfer);
      next_pins.location = addr_q[13:0]; // R22
      // address-line pins ignore polarity
      next_pins.select_two = (ctrl.select_function == port_pkg::SEL_BOTH
          || ctrl.select_function == port_pkg::SEL_TWO_ONLY) // R05
          ? level(in_xfer && addr_q[15], ctrl.select_two_polarity) // R06
          : addr_q[15]; // R07
      next_pins.select_one = (ctrl.select_function == port_pkg::SEL_BOTH)
          ? level(in_xfer && addr_q[14], ctrl.select_one_polarity)
          : addr_q[14]; // R07
      if (ctrl.addr_data_mux_sel == port_pkg::MUX_SEPARATE) begin
        next_pins.low_latch = addr_q[0]; // R07
        next_pins.high_latch = addr_q[1];
      end else begin
        next_pins.low_latch = level(state == port_pkg::ST_ADDR_LOW,
                                    ctrl.latch_polarity); // R06
        next_pins.high_latch = level(state == port_pkg::ST_ADDR_HIGH,
                                     ctrl.latch_polarity);
      end
      next_pins.byte_enable = level(in_xfer && byte_hi,
                                    ctrl.byte_enable_polarity);
      next_pins.byte_enable_oe = ctrl.byte_enable_out_on
                                 && mode_r.wide_data_sel; // R04
      if (mode_r.port_mode_sel == port_pkg::MODE_MASTER1) begin // R08
        next_pins.read_strobe = level(in_xfer && !is_write,
                                      ctrl.read_strobe_polarity);
        next_pins.write_strobe = level(state == port_pkg::ST_STROBE,
                                       ctrl.write_strobe_polarity);
      end else begin
        next_pins.read_strobe = level(state == port_pkg::ST_STROBE
            && !is_write, ctrl.read_strobe_polarity);
        next_pins.write_strobe = level(state == port_pkg::ST_STROBE
            && is_write, ctrl.write_strobe_polarity);
      end
      next_pins.read_strobe_oe = ctrl.read_strobe_out_on; // R04
      next_pins.write_strobe_oe = ctrl.write_strobe_out_on;
    end else if (slave_on) begin
      next_pins.data_out = out_buf[idx_r];
      next_pins.data_oe = rd_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pins <= '0;
    else
      pins <= next_pins;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_off_no_drive: assert property ( // R01
    !ctrl.port_on |=> !pins.data_oe && !pins.read_strobe_oe)
    else $error("port drives while off");
  a_busy_reads: assert property ( // R09
    master && state != port_pkg::ST_IDLE |-> read_value[15] ||
    haddr[7:0] != port_pkg::OFF_MODE)
    else $error("busy flag low during transfer");
  a_event_at_end: assert property ( // R10
    xfer_done && mode_r.interrupt_select == port_pkg::EVT_END
    |=> port_event)
    else $error("no event at cycle end");
  a_step_up: assert property ( // R12
    xfer_done && mode_r.step_select == port_pkg::STEP_UP && !wr_en
    |=> addr_q[STEP_BITS-1:0] == $past(addr_q[STEP_BITS-1:0]) + 1'b1)
    else $error("address did not step up");
  a_short_strobe: assert property ( // R19
    active && state == port_pkg::ST_STROBE && mode_r.strobe_wait == 4'h0
    && ctrl.port_on |=> state == port_pkg::ST_GAP)
    else $error("zero wait strobe not one cycle");
  a_gap_before_idle: assert property ( // R20
    ctrl.port_on && state != port_pkg::ST_IDLE
    && state != port_pkg::ST_GAP ##1 ctrl.port_on
    |-> state != port_pkg::ST_IDLE)
    else $error("no idle cycle between operations");
  a_overflow_sets: assert property ( // R21
    s_wr && in_full[idx_w] |=> ovf)
    else $error("overflow not flagged");
  a_overflow_holds: assert property ( // R21
    ovf && !ovf_clear |=> ovf)
    else $error("overflow flag lost");
  a_select_addr: assert property ( // R07
    ctrl.port_on && master && ctrl.select_function == port_pkg::SEL_ADDRESS
    |=> pins.select_one == $past(addr_q[14]))
    else $error("select pin not address bit");

endmodule

/* shared/port_pkg.sv */
package port_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OUT_BYTES = 8'h14;
  localparam logic [7:0] OFF_IN_BYTES = 8'h18;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] ADDRESS_RESET = 16'h0000;
  localparam logic [3:0] OUT_EMPTY_RESET = 4'hF;
  localparam int OVERFLOW_BIT = 14;

  // ****************************************************************
  // field encodings
  // ****************************************************************
  localparam logic [1:0] MUX_SEPARATE = 2'h0;
  localparam logic [1:0] MUX_PARTIAL = 2'h1;
  localparam logic [1:0] MUX_FULL = 2'h2;
  localparam logic [1:0] SEL_ADDRESS = 2'h0;
  localparam logic [1:0] SEL_TWO_ONLY = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_END = 2'h1;
  localparam logic [1:0] EVT_STALL = 2'h2;
  localparam logic [1:0] EVT_BUF3 = 2'h3;
  localparam logic [1:0] STEP_UP = 2'h1;
  localparam logic [1:0] STEP_DOWN = 2'h2;
  localparam logic [1:0] STEP_BUFFER = 2'h3;
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ADDRESSED = 2'h1;
  localparam logic [1:0] MODE_MASTER2 = 2'h2;
  localparam logic [1:0] MODE_MASTER1 = 2'h3;
  localparam logic [1:0] LAST_BUFFER = 2'h3;

  typedef struct packed {
    logic port_on;
    logic unused_14;
    logic halt_in_idle;
    logic [1:0] addr_data_mux_sel;
    logic byte_enable_out_on;
    logic write_strobe_out_on;
    logic read_strobe_out_on;
    logic [1:0] select_function;
    logic latch_polarity;
    logic select_two_polarity;
    logic select_one_polarity;
    logic byte_enable_polarity;
    logic write_strobe_polarity;
    logic read_strobe_polarity;
  } control_type;

  typedef struct packed {
    logic busy;
    logic [1:0] interrupt_select;
    logic [1:0] step_select;
    logic wide_data_sel;
    logic [1:0] port_mode_sel;
    logic [1:0] setup_wait;
    logic [3:0] strobe_wait;
    logic [1:0] hold_wait;
  } mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR_LOW = 3'h1,
    ST_ADDR_HIGH = 3'h2,
    ST_SETUP = 3'h3,
    ST_STROBE = 3'h4,
    ST_HOLD = 3'h5,
    ST_GAP = 3'h6
  } phase_type;

  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
    logic [13:0] location;
    logic select_one;
    logic select_two;
    logic read_strobe;
    logic read_strobe_oe;
    logic write_strobe;
    logic write_strobe_oe;
    logic byte_enable;
    logic byte_enable_oe;
    logic low_latch;
    logic high_latch;
  } pins_out_type;

  typedef struct packed {
    logic [7:0] data_in;
    logic read_strobe_in;
    logic write_strobe_in;
    logic select_one_in;
    logic [1:0] location_in;
  } pins_in_type;

endpackage

/* verification/peripheral_model.sv */
`timescale 1ns/1ps
// ***********************************
// far-side byte memory
// ***********************************
module peripheral_model (
  input wire logic hclk, // bus clock
  input wire port_pkg::pins_out_type pins, // port outputs
  input wire logic host_wr, // far host write strobe, active high
  input wire logic [7:0] host_data, // far host write byte
  output port_pkg::pins_in_type pins_in // port inputs
);
  logic [7:0] mem [16];
  logic [7:0] last = 8'h00;
  logic [3:0] idx;
  // byte enable picks the upper half so wide pairs land apart
  assign idx = {pins.byte_enable, pins.location[2:0]};
  always_ff @(posedge hclk) begin
    if (pins.write_strobe && pins.write_strobe_oe) mem[idx] <= pins.data_out;
    if (pins.read_strobe) last <= mem[idx];
  end
  // released bus shows the inverse so a late sample cannot pass
  always_comb begin
    pins_in = '0;
    pins_in.write_strobe_in = host_wr;
    if (host_wr)
      pins_in.data_in = host_data;
    else
      pins_in.data_in = pins.read_strobe ? mem[idx] : ~last;
  end
endmodule

/* verification/tb_parallel_port.sv */
`timescale 1ns/1ps
module tb_parallel_port;
  logic hclk = 0;
  logic hresetn = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [31:0] hwdata = '0;
  logic cpu_idle = 0;
  logic rd_dp = 0;
  logic host_wr = 0;
  logic [7:0] host_data = '0;
  logic hreadyout, hresp, port_event;
  logic [31:0] hrdata, e;
  port_pkg::pins_in_type pins_in;
  port_pkg::pins_out_type pins;
  logic [31:0] exp_q[$];
  logic [15:0] modes [4] = '{16'h4A04, 16'h4AC3, 16'h4AFF, 16'h4E04};
  logic [15:0] w;
  logic [2:0] a;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 hclk = ~hclk;
  parallel_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cpu_idle(cpu_idle),
    .port_event(port_event), .pins_in(pins_in), .pins(pins));
  peripheral_model far_u (.hclk(hclk), .pins(pins), .host_wr(host_wr),
    .host_data(host_data), .pins_in(pins_in));
  // ***********************************
  // bus tasks and result watcher
  // ***********************************
  task automatic xfer(input logic [7:0] ad, input logic wr,
                      input logic [31:0] wd);
    haddr <= {24'h00_0000, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    rd_dp <= !wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask
  task automatic host_write(input logic [7:0] d);
    host_data <= d;
    host_wr <= 1'b1;
    @(posedge hclk);
    host_wr <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    exp_q.push_back(ex);
    xfer(ad, 1'b0, '0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (rd_dp && hreadyout) begin
      e = exp_q.pop_front();
      total_checks++;
      if (hrdata !== e) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got %h exp %h", $time, hrdata, e);
      end
    end
    if (cycles > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    w = 16'($urandom(32'h0000_2790));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, '0);
    rd(8'h04, '0);
    rd(8'h10, 32'h0000_008F);
    rd(8'h1C, '0);
    $display("reset test done");
    xfer(8'h00, 1'b1, 32'h0000_8707);
    for (int m = 0; m < 4; m++) begin
      xfer(8'h04, 1'b1, {16'h0000, modes[m]});
      rd(8'h04, {16'h0000, modes[m]});
      repeat (2) begin
        a = 3'($urandom);
        w = 16'($urandom);
        xfer(8'h08, 1'b1, {29'h0, a});
        xfer(8'h0C, 1'b1, {16'h0000, w});
        rd(8'h08, {29'h0, a} + 32'h1);
        xfer(8'h08, 1'b1, {29'h0, a});
        if (m == 3) rd(8'h0C, {16'h0000, w});
        else rd(8'h0C, {24'h00_0000, w[7:0]});
      end
      $display("mode %h test done", modes[m]);
    end
    xfer(8'h04, 1'b1, 32'h0000_3204);
    xfer(8'h08, 1'b1, 32'h0000_0008);
    xfer(8'h0C, 1'b1, 32'h0000_00A5);
    rd(8'h04, 32'h0000_B204);
    // a missing completion pulse ends in the timeout
    while (port_event !== 1'b1) @(posedge hclk);
    rd(8'h08, 32'h0000_0007);
    $display("step down test done");
    xfer(8'h04, 1'b1, 32'h0000_0000);
    w = 16'($urandom);
    host_write(w[7:0]);
    host_write(~w[7:0]);
    rd(8'h10, 32'h0000_418F);
    rd(8'h18, {24'h00_0000, w[7:0]});
    xfer(8'h10, 1'b1, 32'h0000_0000);
    rd(8'h10, 32'h0000_008F);
    $display("slave test done");
    test_done();
  end
endmodule
